// ===== verilog/sectmr_pkg.sv
// Constants for the secondary 16-bit timer: register map, control fields,
// prescale codes and prescaler terminal counts.
// Assumes a classic Wishbone master with 32-bit data and one clock domain.
`default_nettype none

package sectmr_pkg;

  // Byte addresses of the registers on the bus.
  localparam logic [3:0] CTRL_ADDR  = 4'h0;  // Control register.
  localparam logic [3:0] COUNT_ADDR = 4'h4;  // Timer count, read/write.
  localparam logic [3:0] PERIOD_ADDR = 4'h8; // Period, compare value.
  localparam logic [3:0] STATUS_ADDR = 4'hc; // Live state, read only.

  // Control field positions.
  localparam int RUN_BIT   = 15;
  localparam int HALT_BIT  = 13;
  localparam int GATE_BIT  = 6;
  localparam int PSC_HI    = 5;
  localparam int PSC_LO    = 4;
  localparam int SRC_BIT   = 1;

  // Writable bits of the control register; all others stay zero.
  localparam logic [15:0] CTRL_MASK  = 16'ha072;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hffff;

  // Prescale codes.
  localparam logic [1:0] PSC_DIV1   = 2'h0;
  localparam logic [1:0] PSC_DIV8   = 2'h1;
  localparam logic [1:0] PSC_DIV64  = 2'h2;
  localparam logic [1:0] PSC_DIV256 = 2'h3;

  // Terminal counts of the prescaler for each ratio.
  localparam logic [7:0] PSC_TOP1   = 8'h00;
  localparam logic [7:0] PSC_TOP8   = 8'h07;
  localparam logic [7:0] PSC_TOP64  = 8'h3f;
  localparam logic [7:0] PSC_TOP256 = 8'hff;

  // Width of the prescaler counter.
  localparam int PSC_WIDTH = 8;

endpackage : sectmr_pkg

`default_nettype wire

// ===== verilog/sectmr_prescaler.sv
// Input prescaler of the secondary timer.
// Assumes one clock; input ticks are single-cycle qualified pulses.
`default_nettype none

module sectmr_prescaler
(
  // Clock, reset and enable.
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  input  wire logic       clk_en_in,
  // Control.
  input  wire logic [1:0] psc_sel_in,
  input  wire logic       clear_in,
  input  wire logic       tick_in,
  // Divided tick.
  output logic            tick_out
);

  // Running count of input ticks since the last divided tick.
  logic [sectmr_pkg::PSC_WIDTH-1:0] psc_reg;

  // Terminal count for the selected ratio.
  function automatic logic [7:0] psc_top(input logic [1:0] sel);
    unique case (sel)
      sectmr_pkg::PSC_DIV1:   psc_top = sectmr_pkg::PSC_TOP1;
      sectmr_pkg::PSC_DIV8:   psc_top = sectmr_pkg::PSC_TOP8;
      sectmr_pkg::PSC_DIV64:  psc_top = sectmr_pkg::PSC_TOP64;
      sectmr_pkg::PSC_DIV256: psc_top = sectmr_pkg::PSC_TOP256;
    endcase
  endfunction : psc_top

  // Divided tick is combinational so that the count moves on the same edge.
  assign tick_out = tick_in && (psc_reg == psc_top(psc_sel_in));

  // Prescaler count; cleared while the timer is stopped so that a fresh
  // start always waits a full ratio.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      psc_reg <= '0;
    else if (clk_en_in)
    begin
      if (clear_in)
        psc_reg <= '0;
      else if (tick_out)
        psc_reg <= '0;
      else if (tick_in)
        psc_reg <= psc_reg + 8'h01;
    end
  end

  // A prescaler that passes its terminal count would not tick again until its 8-bit count wraps.
  psc_bound_a : assert property (@(posedge core_clk_in) disable iff (rst_in)
    psc_reg <= psc_top(psc_sel_in) || $changed(psc_sel_in))
    else $error("Prescaler count passed its terminal value.");

endmodule : sectmr_prescaler

`default_nettype wire

// ===== verilog/sectmr_edge.sv
// Rising-edge detector for the external count pin.
// The pin is taken as synchronous to the core clock.
`default_nettype none

module sectmr_edge
(
  // Clock, reset and enable.
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  input  wire logic clk_en_in,
  // Pin level and detected edge.
  input  wire logic pin_in,
  output logic      rise_out
);

  // Previous pin level.
  logic last_reg;

  // Edge is a one-cycle pulse on a low-to-high change.
  assign rise_out = pin_in && !last_reg;

  // Track the pin level; resets low so a pin high at release counts once.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      last_reg <= 1'b0;
    else if (clk_en_in)
      last_reg <= pin_in;
  end

endmodule : sectmr_edge

`default_nettype wire

// ===== verilog/sectmr_top.sv
// Secondary 16-bit timer with its control register on classic Wishbone.
// Assumes synchronous pins, one clock and a single-beat Wishbone master.
`default_nettype none

module sectmr_top
(
  // Clock, reset and enable.
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        clk_en_in,
  // Wishbone slave.
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [3:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  // Device state and pins.
  input  wire logic        idle_mode_in,
  input  wire logic        pair_wide_mode_in,
  input  wire logic        gate_in,
  input  wire logic        external_count_pin_in,
  // Timer outputs.
  output logic [15:0]      timer_value_out,
  output logic             period_match_out
);

  // Software-visible state.
  logic [15:0] ctrl_reg;      // Control register.
  logic [15:0] count_reg;     // Timer value.
  logic [15:0] period_reg;    // Period; count wraps after it.
  logic        match_reg;     // Registered period match pulse.
  logic        ack_reg;       // Bus acknowledge.
  logic [31:0] rdata_reg;     // Bus read data.

  // Decoded controls.
  logic        timer_run;
  logic        halt_in_idle;
  logic        gated_accumulate;
  logic [1:0]  prescale_select;
  logic        clock_source_select;

  // Counting qualifiers.
  logic        active;        // Timer may count this cycle.
  logic        ext_rise;      // Rising edge on the count pin.
  logic        raw_tick;      // Undivided timer input tick.
  logic        div_tick;      // Prescaled tick.
  logic        bus_req;       // New bus request this cycle.
  logic        bus_wr;        // New bus write request this cycle.
  logic        ctrl_wr;       // Control write takes effect this cycle.
  logic        count_wr;      // Count write takes effect this cycle.
  logic        wrap_now;      // Tick that wraps the count to zero.

  assign timer_run           = ctrl_reg[sectmr_pkg::RUN_BIT];
  assign halt_in_idle        = ctrl_reg[sectmr_pkg::HALT_BIT];
  assign gated_accumulate    = ctrl_reg[sectmr_pkg::GATE_BIT];
  assign prescale_select     = ctrl_reg[sectmr_pkg::PSC_HI:sectmr_pkg::PSC_LO];
  assign clock_source_select = ctrl_reg[sectmr_pkg::SRC_BIT];

  // Wide pair mode hands control to the partner, so this register's bits
  // lose their effect; the partner drives the pair elsewhere.
  assign active = !pair_wide_mode_in
                  && timer_run
                  && !(halt_in_idle && idle_mode_in);

  // Source select; the gate only qualifies the internal clock.
  always_comb
  begin
    if (clock_source_select)
      raw_tick = ext_rise;
    else if (gated_accumulate)
      raw_tick = gate_in;
    else
      raw_tick = 1'b1;
  end

  // Edge detector for the external pin.
  sectmr_edge u_edge
  (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .clk_en_in   (clk_en_in),
    .pin_in      (external_count_pin_in),
    .rise_out    (ext_rise)
  );

  // Prescaler; held clear whenever the timer cannot count and on every
  // control write, so a new ratio never starts from a stale count.
  // Ticks are qualified by the clock enable so a frozen cycle adds none.
  sectmr_prescaler u_psc
  (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .clk_en_in   (clk_en_in),
    .psc_sel_in  (prescale_select),
    .clear_in    (!active || ctrl_wr),
    .tick_in     (raw_tick && active && clk_en_in),
    .tick_out    (div_tick)
  );

  // A request is new when strobed and not already answered.
  assign bus_req = wb_cyc_in && wb_stb_in && !ack_reg;
  assign bus_wr  = bus_req && wb_we_in;

  // Register writes and the wrapping tick, shared by logic and checks.
  assign ctrl_wr  = clk_en_in && bus_wr
                    && wb_adr_in == sectmr_pkg::CTRL_ADDR;
  assign count_wr = clk_en_in && bus_wr
                    && wb_adr_in == sectmr_pkg::COUNT_ADDR;
  assign wrap_now = div_tick && !count_wr && count_reg == period_reg;

  // Merge a write into a 16-bit register under the low two byte lanes.
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  sel);
    lane_merge = old;
    if (sel[0])
      lane_merge[7:0] = data[7:0];
    if (sel[1])
      lane_merge[15:8] = data[15:8];
  endfunction : lane_merge

  // Control register; only implemented bits are ever stored.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      ctrl_reg <= sectmr_pkg::CTRL_RESET;
    else if (clk_en_in && bus_wr && wb_adr_in == sectmr_pkg::CTRL_ADDR)
      ctrl_reg <= lane_merge(ctrl_reg, wb_dat_in, wb_sel_in)
                  & sectmr_pkg::CTRL_MASK;
  end

  // Period register.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      period_reg <= sectmr_pkg::PERIOD_RESET;
    else if (clk_en_in && bus_wr && wb_adr_in == sectmr_pkg::PERIOD_ADDR)
      period_reg <= lane_merge(period_reg, wb_dat_in, wb_sel_in);
  end

  // Timer count; a software write wins over a tick in the same cycle.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      count_reg <= sectmr_pkg::COUNT_RESET;
    else if (clk_en_in)
    begin
      if (bus_wr && wb_adr_in == sectmr_pkg::COUNT_ADDR)
        count_reg <= lane_merge(count_reg, wb_dat_in, wb_sel_in);
      else if (div_tick && count_reg == period_reg)
        count_reg <= 16'h0000;
      else if (div_tick)
        count_reg <= count_reg + 16'h0001;
    end
  end

  // Period match pulse, one cycle per wrap.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      match_reg <= 1'b0;
    else if (clk_en_in)
      match_reg <= div_tick && count_reg == period_reg
                   && !(bus_wr && wb_adr_in == sectmr_pkg::COUNT_ADDR);
  end

  // Bus answer: ack one cycle after the request, dropped the cycle after.
  // Unmapped addresses still ack and read zero, so a master never hangs.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else if (clk_en_in)
    begin
      ack_reg <= bus_req;
      if (bus_req && !wb_we_in)
      begin
        unique case (wb_adr_in)
          sectmr_pkg::CTRL_ADDR:
            rdata_reg <= {16'h0000, ctrl_reg};
          sectmr_pkg::COUNT_ADDR:
            rdata_reg <= {16'h0000, count_reg};
          sectmr_pkg::PERIOD_ADDR:
            rdata_reg <= {16'h0000, period_reg};
          sectmr_pkg::STATUS_ADDR:
            rdata_reg <= {29'h0000_0000, pair_wide_mode_in,
                          idle_mode_in, active};
          default:
            rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_out       = ack_reg;
  assign wb_dat_out       = rdata_reg;
  assign timer_value_out  = count_reg;
  assign period_match_out = match_reg;

  // One frozen step: nothing can tick and software leaves the count alone.
  sequence frozen_step_s;
    clk_en_in && !active && !count_wr;
  endsequence

  // A new request taken on this edge.
  sequence bus_take_s;
    clk_en_in && wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence

  // Ack high for one cycle, then low again.
  sequence ack_drop_s;
    wb_ack_out ##1 !wb_ack_out;
  endsequence

  // Without a software count write, the count never moves while stopped, halted in idle or in wide mode.
  hold_stopped_a : assert property (@(posedge core_clk_in) disable iff (rst_in)
    frozen_step_s |=> $stable(count_reg))
    else $error("Count moved while the timer was inactive.");

  // Idle with halt set blocks counting.
  idle_halt_a : assert property (@(posedge core_clk_in) disable iff (rst_in)
    idle_mode_in && halt_in_idle |-> !div_tick)
    else $error("Timer ticked while halted in idle.");

  // Gate low on the internal clock yields no tick.
  gate_block_a : assert property (@(posedge core_clk_in) disable iff (rst_in)
    !clock_source_select && gated_accumulate && !gate_in |-> !div_tick)
    else $error("Gated timer ticked with the gate low.");

  // Divide by one counts every enabled cycle.
  div_one_a : assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && active && !clock_source_select && !gated_accumulate
    && prescale_select == sectmr_pkg::PSC_DIV1 |-> div_tick)
    else $error("Undivided internal clock missed a tick.");

  // External source ticks only on a pin rising edge.
  ext_edge_a : assert property (@(posedge core_clk_in) disable iff (rst_in)
    clock_source_select && div_tick && $past(clk_en_in)
    |-> external_count_pin_in
    && !$past(external_count_pin_in))
    else $error("External tick without a pin rising edge.");

  // Wide pair mode freezes this timer's own counting.
  wide_ignore_a : assert property (@(posedge core_clk_in) disable iff (rst_in)
    pair_wide_mode_in |-> !div_tick)
    else $error("Timer ticked in wide pair mode.");

  // Unimplemented control bits always read back zero.
  ctrl_zero_a : assert property (@(posedge core_clk_in) disable iff (rst_in)
    (ctrl_reg & ~sectmr_pkg::CTRL_MASK) == 16'h0000)
    else $error("Unimplemented control bit is set.");

  // Divide by eight: a tick is followed by seven quiet cycles.
  div_eight_a : assert property (@(posedge core_clk_in) disable iff (rst_in)
    div_tick && active && !clock_source_select && !gated_accumulate
    && prescale_select == sectmr_pkg::PSC_DIV8 && clk_en_in
    |=> (!div_tick || prescale_select != sectmr_pkg::PSC_DIV8) [*7])
    else $error("Divide-by-eight ticked early.");

  // Ack lasts exactly one cycle.
  ack_pulse_a : assert property (@(posedge core_clk_in) disable iff (rst_in)
    wb_ack_out && clk_en_in |=> !wb_ack_out)
    else $error("Bus ack held longer than one cycle.");

  // A taken request is answered next cycle by a one-cycle ack.
  ack_answer_a : assert property (@(posedge core_clk_in) disable iff (rst_in)
    bus_take_s ##1 clk_en_in |-> ack_drop_s)
    else $error("Bus request not answered by a one-cycle ack.");

  // Each prescaled tick below the period and clear of a count write adds exactly one to the count.
  count_step_a : assert property (@(posedge core_clk_in) disable iff (rst_in)
    div_tick && !count_wr && count_reg != period_reg
    |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("Count did not step by one on a tick.");

  // The wrapping tick clears the count and raises the match pulse.
  wrap_match_a : assert property (@(posedge core_clk_in) disable iff (rst_in)
    wrap_now |=> count_reg == 16'h0000 && period_match_out)
    else $error("Period wrap did not clear the count with a match.");

  // A match pulse only ever follows a wrapping tick.
  match_cause_a : assert property (@(posedge core_clk_in) disable iff (rst_in)
    period_match_out && $past(clk_en_in) |-> $past(wrap_now))
    else $error("Match pulse without a wrapping tick.");

  // A cleared run bit lets no tick through in any mode.
  run_gate_a : assert property (@(posedge core_clk_in) disable iff (rst_in)
    !timer_run |-> !div_tick)
    else $error("Timer ticked with the run bit clear.");

  // The pin source ignores cycles without a rising edge.
  ext_quiet_a : assert property (@(posedge core_clk_in) disable iff (rst_in)
    clock_source_select && !ext_rise |-> !div_tick)
    else $error("External source ticked without a pin edge.");

  // A full control write stores exactly its implemented bits.
  ctrl_write_a : assert property (@(posedge core_clk_in) disable iff (rst_in)
    ctrl_wr && wb_sel_in == 4'h3
    |=> ctrl_reg == (16'($past(wb_dat_in)) & sectmr_pkg::CTRL_MASK))
    else $error("Control write stored the wrong bits.");

  // A software count write wins over a tick in the same cycle.
  write_wins_a : assert property (@(posedge core_clk_in) disable iff (rst_in)
    count_wr && wb_sel_in == 4'h3
    |=> count_reg == 16'($past(wb_dat_in)))
    else $error("Count write lost against a tick.");

endmodule : sectmr_top

`default_nettype wire

// ===== tb/stc_pin_model.sv
// Model of the source that drives the external count pin.
// Assumes the pin is synchronous to the core clock and idles low.
`default_nettype none

module stc_pin_model
(
  // Clock and reset.
  input  wire logic   core_clk_in,
  input  wire logic   rst_in,
  // Burst control.
  input  wire logic   run_in,
  // Pin level and the number of rising edges made so far.
  output logic        pin_out,
  output logic [15:0] edges_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] phase_reg;  // Cycles since the last toggle.

  // Toggle every third cycle in a burst and rest low between bursts.
  // The pin is pulled low at once when a burst ends, so that no stray
  // rising edge is left for the timer after the bench stops counting.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      phase_reg <= 2'h0;
      pin_out   <= 1'b0;
      edges_out <= 16'h0000;
    end
    else if (!run_in)
    begin
      phase_reg <= 2'h0;
      pin_out   <= 1'b0;
    end
    else if (phase_reg == 2'h2)
    begin
      phase_reg <= 2'h0;
      pin_out   <= !pin_out;
      // Each low-to-high step is one edge the timer must count.
      if (!pin_out)
        edges_out <= edges_out + 16'h0001;
    end
    else
      phase_reg <= phase_reg + 2'h1;
  end
endmodule : stc_pin_model

`default_nettype wire

// ===== tb/secondary_timer_control_test.sv
// Self-checking bench for the secondary timer and its control register.
// Assumes the design files are compiled first; one 125 MHz clock.
`default_nettype none

module secondary_timer_control_test;
  timeunit 1ns;
  timeprecision 1ps;

  // One row: control word and pin levels, and whether the count moves.
  typedef struct packed
  {
    logic [15:0] ctrl;
    logic        idle;
    logic        wide;
    logic        gate;
    logic        moving;
  } stc_row_s;

  logic        core_clk;      // Bench clock.
  logic        rst;           // Asynchronous reset.
  logic        wb_cyc;        // Bus cycle.
  logic        wb_stb;        // Bus strobe.
  logic        wb_we;         // Bus direction.
  logic [3:0]  wb_adr;        // Bus byte address.
  logic [3:0]  wb_sel;        // Bus byte lanes.
  logic [31:0] wb_dat;        // Bus write data.
  logic [31:0] wb_dat_out;    // Bus read data.
  logic        wb_ack_out;    // Bus acknowledge.
  logic        idle;          // Processor idle level.
  logic        wide;          // Partner runs the pair as one wide timer.
  logic        gate;          // Gate input.
  logic        pin;           // External count pin from the model.
  logic        pin_run;       // Starts a burst of pin edges.
  logic [15:0] edges;         // Edges the model has made.
  logic [15:0] timer_value_out; // Live count.
  logic        period_match_out; // Wrap pulse.
  int          waited;        // Cycles spent waiting for an event.
  logic [31:0] rd;            // Last read data.
  logic [15:0] c0;            // Count before a burst.
  logic [15:0] e0;            // Edge tally before a burst.
  int          num_errors;    // Mismatches seen.
  int          checks_done;   // Comparisons made.

  // Ordinary cases; the count is watched for 16 cycles at each.
  stc_row_s rows [9] = '{
    '{16'h8000, 1'b0, 1'b0, 1'b0, 1'b1},
    '{16'h0000, 1'b0, 1'b0, 1'b0, 1'b0},
    '{16'ha000, 1'b1, 1'b0, 1'b0, 1'b0},
    '{16'h8000, 1'b1, 1'b0, 1'b0, 1'b1},
    '{16'ha000, 1'b0, 1'b0, 1'b0, 1'b1},
    '{16'h8040, 1'b0, 1'b0, 1'b0, 1'b0},
    '{16'h8040, 1'b0, 1'b0, 1'b1, 1'b1},
    '{16'ha000, 1'b0, 1'b1, 1'b0, 1'b0},
    '{16'h8000, 1'b1, 1'b1, 1'b0, 1'b0}
  };

  // Half period of 4 ns gives the 125 MHz clock.
  always #4 core_clk = !core_clk;

  sectmr_top u_sectmr_top (.core_clk_in(core_clk), .rst_in(rst),
    .clk_en_in(1'b1), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb),
    .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel),
    .wb_dat_in(wb_dat), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .idle_mode_in(idle), .pair_wide_mode_in(wide), .gate_in(gate),
    .external_count_pin_in(pin), .timer_value_out(timer_value_out),
    .period_match_out(period_match_out));

  stc_pin_model u_stc_pin_model (.core_clk_in(core_clk), .rst_in(rst),
    .run_in(pin_run), .pin_out(pin), .edges_out(edges));

  // Counts one comparison and reports it if it fails.
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One classic cycle; held until ack is sampled high, then released.
  task automatic wb(input logic we, input logic [3:0] adr,
                    input logic [31:0] wdat, output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_sel <= 4'h3;
    wb_adr <= adr;
    wb_dat <= wdat;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wb_ack_out !== 1'b1 && n < 50);
    rdat = wb_dat_out;
    check("bus ack", 32'h1, {31'h0, wb_ack_out});
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb

  // Runs with one prescale code and times the gap between two steps.
  task automatic measure(input logic [1:0] psc, input int ratio);
    logic [15:0] v;
    int          n;
    wb(1'b1, sectmr_pkg::CTRL_ADDR, {16'h0, 8'h80, 2'h0, psc, 4'h0}, rd);
    @(posedge core_clk);
    for (int k = 0; k < 2; k++)
    begin
      v = timer_value_out;
      n = 0;
      while (timer_value_out === v && n < 600)
      begin
        @(posedge core_clk);
        n++;
      end
    end
    check("tick spacing", ratio, n);
    check("count step", {16'h0, 16'(v + 16'h1)}, {16'h0, timer_value_out});
  endtask : measure

  // Prints the verdict and ends the run.
  task automatic summarize();
    if (num_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  // Cuts a hang short well beyond the thousand or so cycles needed.
  initial
  begin
    #200000;
    num_errors++;
    summarize();
  end

  // Main sequence: reset values, rows, prescale codes, pin counting.
  initial
  begin
    core_clk = 1'b0;
    rst <= 1'b1;
    {wb_cyc, wb_stb, wb_we, idle, wide, gate, pin_run} <= 7'h00;
    wb_adr <= 4'h0;
    wb_sel <= 4'h3;
    wb_dat <= 32'h0;
    num_errors = 0;
    checks_done = 0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    wb(1'b0, sectmr_pkg::CTRL_ADDR, 32'h0, rd);
    check("ctrl reset", 32'h0, rd);
    wb(1'b0, sectmr_pkg::PERIOD_ADDR, 32'h0, rd);
    check("period reset", 32'h0000_ffff, rd);
    // Unimplemented control bits and an unmapped place read zero.
    wb(1'b1, sectmr_pkg::CTRL_ADDR, 32'hffff_ffff, rd);
    wb(1'b0, sectmr_pkg::CTRL_ADDR, 32'h0, rd);
    check("ctrl mask", 32'h0000_a072, rd);
    wb(1'b1, 4'h2, 32'hffff_ffff, rd);
    wb(1'b0, 4'h2, 32'h0, rd);
    check("unmapped read", 32'h0, rd);
    foreach (rows[i])
    begin
      idle <= rows[i].idle;
      wide <= rows[i].wide;
      gate <= rows[i].gate;
      wb(1'b1, sectmr_pkg::CTRL_ADDR, {16'h0, rows[i].ctrl}, rd);
      repeat (3) @(posedge core_clk);
      c0 = timer_value_out;
      repeat (16) @(posedge core_clk);
      check($sformatf("row %0d moving", i), {31'h0, rows[i].moving},
            {31'h0, timer_value_out !== c0});
    end
    {idle, wide, gate} <= 3'h0;
    measure(sectmr_pkg::PSC_DIV1, 1);
    measure(sectmr_pkg::PSC_DIV8, 8);
    measure(sectmr_pkg::PSC_DIV64, 64);
    measure(sectmr_pkg::PSC_DIV256, 256);
    // Pin source with the gate bit set and the gate low: only edges count.
    wb(1'b1, sectmr_pkg::CTRL_ADDR, 32'h0000_8042, rd);
    wb(1'b0, sectmr_pkg::COUNT_ADDR, 32'h0, rd);
    c0 = rd[15:0];
    e0 = edges;
    pin_run <= 1'b1;
    repeat (60) @(posedge core_clk);
    pin_run <= 1'b0;
    repeat (4) @(posedge core_clk);
    wb(1'b0, sectmr_pkg::COUNT_ADDR, 32'h0, rd);
    check("pin edges", {16'h0, 16'(edges - e0)}, {16'h0, 16'(rd[15:0] - c0)});
    // Short period, software count load, live status and wrap match.
    wb(1'b1, sectmr_pkg::CTRL_ADDR, 32'h0, rd);
    wb(1'b1, sectmr_pkg::PERIOD_ADDR, 32'h0000_0004, rd);
    wb(1'b1, sectmr_pkg::COUNT_ADDR, 32'h0000_0002, rd);
    wb(1'b0, sectmr_pkg::COUNT_ADDR, 32'h0, rd);
    check("count load", 32'h0000_0002, rd);
    wb(1'b1, sectmr_pkg::CTRL_ADDR, 32'h0000_8000, rd);
    waited = 0;
    while (period_match_out !== 1'b1 && waited < 20)
    begin
      @(posedge core_clk);
      waited++;
    end
    check("wrap match", 32'h1, {31'h0, period_match_out});
    check("wrap count", 32'h0, {16'h0, timer_value_out});
    @(posedge core_clk);
    check("match width", 32'h0, {31'h0, period_match_out});
    check("after wrap", 32'h1, {16'h0, timer_value_out});
    wb(1'b0, sectmr_pkg::STATUS_ADDR, 32'h0, rd);
    check("status", 32'h1, rd);
    // Reset in mid-run: every register returns to its reset value.
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    wb(1'b0, sectmr_pkg::CTRL_ADDR, 32'h0, rd);
    check("ctrl after reset", 32'h0, rd);
    wb(1'b0, sectmr_pkg::PERIOD_ADDR, 32'h0, rd);
    check("period after reset", 32'h0000_ffff, rd);
    check("count after reset", 32'h0, {16'h0, timer_value_out});
    summarize();
  end
endmodule : secondary_timer_control_test

`default_nettype wire
